// [spr_rx_status.sv]
// Receiver error flags, status decode, block buffers and sync detection
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "spr_params.svh"
module spr_rx_status
    import spr_pkg::*;
#(
    parameter int SYNC_FRAMES = `SPR_SYNC_TIMEOUT,
    parameter int BUF_WORDS   = `SPR_BUF_WORDS
)(
    input  wire logic        mclk,
    input  wire logic        rstn,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        pll_locked,
    input  wire logic        sf_stb,
    input  wire logic        sf_is_b,
    input  wire logic        sf_block_start,
    input  wire logic [23:0] sf_sample,
    input  wire logic        sf_c,
    input  wire logic        sf_u,
    input  wire logic        sf_v,
    input  wire logic        check_bit_error,
    input  wire logic        line_code_error,
    input  wire logic        eye_margin_warning,
    input  wire logic        subcode_check_error,
    input  wire logic        status_block_check_error,
    output logic      [23:0] audio_out,
    output logic             audio_stb,
    output logic             audio_is_b,
    output logic             deemph_on,
    output logic             non_audio,
    output logic             rx_fault_irq,
    output logic             buf_change_irq
);
    localparam int SCW = $clog2(SYNC_FRAMES + 1);

    logic [7:0]     ctrl_ff, err_mask_ff, irq_mask_ff;
    logic [6:0]     err_ff, ev, logged;
    logic           clr_err, hit, lock_ff, v_live_ff, rx_fault_irq_ff;
    logic [23:0]    audio_out_ff, prev_a_ff, prev_b_ff, nxt_sample;
    logic           audio_stb_ff, audio_is_b_ff;
    spr_word_t      dcs_ff [BUF_WORDS];
    spr_word_t      du_ff [BUF_WORDS];
    logic [7:0]     frm_ff, cur_f;
    logic           cap_ff, chg_ff, start, cap_en, diff, blk_done;
    logic [4:0]     w;
    logic [3:0]     cs_pos, u_pos;
    spr_copy_st_t   st_ff;
    logic [5:0]     cnt_ff;
    logic           copy_chg_ff, buf_change_irq_ff;
    logic [39:0]    sel_cs;
    logic           pro_ff, copy_ff, first_generation_flag_ff, cs_aud_ff, emph_ff, deemph_ff;
    logic [3:0]     wlen_ff;
    logic [79:0]    sh_ff;
    logic           seen_ff, match, non_audio_ff;
    logic [SCW-1:0] scnt_ff;
    logic [7:0]     rd_q_ff, rd_mux;
    logic           buf_rd_ff, fmt_user_ff, fmt_two_ff, fmt_pickb_ff;
    logic [4:0]     buf_idx;
    spr_hold_t      hold;

    spr_mem_if #(.AW(6), .DW(16)) mif ();

    spr_blk_mem #(.AW(6), .DW(16), .DEPTH(2 * BUF_WORDS)) u_mem (
        .mclk (mclk),
        .m    (mif.store)
    );

    // Address falls inside the data buffer window
    function automatic logic in_buf(input logic [7:0] a);
        return (a >= `SPR_ADDR_BUF_BASE) && (a < `SPR_ADDR_BUF_END);
    endfunction

    // First generation from category bits 8..14 and the generation bit
    function automatic logic first_gen(input logic [7:0] cat);
        logic inv;
        inv = (cat[2:0] == 3'h1) || (cat[3:0] == 4'h8) || (cat[3:0] == 4'he);
        return inv ? cat[7] : ~cat[7];
    endfunction

    // ==========================================================
    // Control registers written by software
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            ctrl_ff     <= `SPR_CTRL_RST;
            err_mask_ff <= `SPR_MASK_RST;
            irq_mask_ff <= `SPR_MASK_RST;
        end else if (reg_wr) begin
            if (reg_addr == `SPR_ADDR_BUF_CTRL) begin
                ctrl_ff <= reg_wdata;
            end else if (reg_addr == `SPR_ADDR_ERR_MASK) begin
                err_mask_ff <= reg_wdata;
            end else if (reg_addr == `SPR_ADDR_IRQ_MASK) begin
                irq_mask_ff <= reg_wdata;
            end
        end
    end

    // ==========================================================
    // Error events and their masked view
    always_comb begin
        ev                  = '0;
        ev[`SPR_ERR_PAR]    = sf_stb & check_bit_error;
        ev[`SPR_ERR_BIP]    = sf_stb & line_code_error;
        ev[`SPR_ERR_EYE_MARGIN_WARNING]   = sf_stb & eye_margin_warning;
        ev[`SPR_ERR_V]      = sf_stb & sf_v;
        ev[`SPR_ERR_UNLOCK] = ~pll_locked;
        ev[`SPR_ERR_SUBCODE_CHECK_ERROR]   = subcode_check_error;
        ev[`SPR_ERR_STATUS_BLOCK_CHECK_ERROR]   = status_block_check_error;
    end

    assign logged  = ev & err_mask_ff[6:0];
    assign clr_err = reg_rd && (reg_addr == `SPR_ADDR_ERR);
    assign hit     = |(logged & `SPR_ERR_AUDIO);
    assign hold    = spr_hold_t'(ctrl_ff[`SPR_CTRL_HOLD_LO +: 2]);

    // Sticky error flags; a new event beats the clearing read
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            err_ff          <= '0;
            rx_fault_irq_ff <= 1'b0;
        end else begin
            err_ff          <= (clr_err ? 7'h00 : err_ff) | logged;
            rx_fault_irq_ff <= |logged;
        end
    end

    // Live lock and validity mirrors
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            lock_ff   <= 1'b0;
            v_live_ff <= 1'b0;
        end else begin
            lock_ff <= pll_locked;
            if (sf_stb) begin
                v_live_ff <= sf_v;
            end
        end
    end

    // ==========================================================
    // Sample hold or mute on unmasked audio errors (error bits 0 to 4 only)
    always_comb begin
        nxt_sample = sf_sample;
        if (hit) begin
            case (hold)
                SPR_HOLD_PREV: nxt_sample = sf_is_b ? prev_b_ff : prev_a_ff;
                SPR_HOLD_ZERO: nxt_sample = '0;
                default:       nxt_sample = sf_sample;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            audio_out_ff  <= '0;
            audio_stb_ff  <= 1'b0;
            audio_is_b_ff <= 1'b0;
            prev_a_ff     <= '0;
            prev_b_ff     <= '0;
        end else begin
            audio_stb_ff <= sf_stb;
            if (sf_stb) begin
                audio_out_ff  <= nxt_sample;
                audio_is_b_ff <= sf_is_b;
                if (sf_is_b) begin
                    prev_b_ff <= nxt_sample;
                end else begin
                    prev_a_ff <= nxt_sample;
                end
            end
        end
    end

    // ==========================================================
    // Capture buffer: bit positions, MSB first; status A high and B low, user bits A and B interleaved
    assign start    = sf_block_start && !sf_is_b;
    assign cap_en   = sf_stb && (cap_ff || start);
    assign cur_f    = start ? 8'h00 : frm_ff;
    assign w        = cur_f[7:3];
    assign cs_pos   = {~sf_is_b, ~cur_f[2:0]};
    assign u_pos    = ~{cur_f[2:0], sf_is_b};
    assign diff     = (dcs_ff[w][cs_pos] != sf_c) || (du_ff[w][u_pos] != sf_u);
    assign blk_done = cap_en && sf_is_b && (cur_f == 8'(`SPR_BLOCK_FRAMES - 1));

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            frm_ff <= '0;
            cap_ff <= 1'b0;
            chg_ff <= 1'b0;
            for (int i = 0; i < BUF_WORDS; i++) begin
                dcs_ff[i] <= '0;
                du_ff[i]  <= '0;
            end
        end else if (cap_en) begin
            dcs_ff[w][cs_pos] <= sf_c;
            du_ff[w][u_pos]   <= sf_u;
            chg_ff            <= (start ? 1'b0 : chg_ff) | diff;
            cap_ff            <= 1'b1;
            if (sf_is_b) begin
                frm_ff <= blk_done ? 8'h00 : cur_f + 8'h01;
                cap_ff <= !blk_done;
            end
        end
    end

    // ==========================================================
    // Whole-block copy from capture buffer into host buffer
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            st_ff             <= SPR_IDLE;
            cnt_ff            <= '0;
            copy_chg_ff       <= 1'b0;
            buf_change_irq_ff <= 1'b0;
        end else begin
            buf_change_irq_ff <= 1'b0;
            case (st_ff)
                SPR_IDLE: begin
                    if (blk_done) begin
                        st_ff       <= SPR_COPY;
                        cnt_ff      <= '0;
                        copy_chg_ff <= chg_ff | diff;
                    end
                end
                SPR_COPY: begin
                    if (cnt_ff == 6'(2 * BUF_WORDS - 1)) begin
                        st_ff             <= SPR_IDLE;
                        buf_change_irq_ff <= copy_chg_ff & irq_mask_ff[`SPR_IRQ_BUFCHG];
                    end else begin
                        cnt_ff <= cnt_ff + 6'h01;
                    end
                end
                default: st_ff <= SPR_IDLE;
            endcase
        end
    end

    assign mif.wr_en   = (st_ff == SPR_COPY);
    assign mif.wr_addr = cnt_ff;
    assign mif.wr_data = (cnt_ff < 6'(BUF_WORDS)) ? dcs_ff[cnt_ff[4:0]]
                                                   : du_ff[5'(cnt_ff - 6'(BUF_WORDS))];

    // ==========================================================
    // Channel status bits of the selected side
    for (genvar n = 0; n < 40; n++) begin : g_cs
        assign sel_cs[n] = ctrl_ff[`SPR_CTRL_SSEL] ? dcs_ff[n / 8][7 - (n % 8)]
                                                   : dcs_ff[n / 8][15 - (n % 8)];
    end

    // Decodes latched when a block completes
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pro_ff    <= 1'b0;
            copy_ff   <= 1'b0;
            first_generation_flag_ff   <= 1'b0;
            cs_aud_ff <= 1'b0;
            emph_ff   <= 1'b0;
            wlen_ff   <= '0;
        end else if (blk_done) begin
            pro_ff    <= sel_cs[0];
            copy_ff   <= ~sel_cs[2] | (sel_cs[14:8] == 7'h00);
            first_generation_flag_ff   <= first_gen(sel_cs[15:8]);
            cs_aud_ff <= sel_cs[1];
            emph_ff   <= ~sel_cs[0] & sel_cs[3] & ~sel_cs[4] & ~sel_cs[5];
            wlen_ff   <= sel_cs[35:32];
        end
    end

    // ==========================================================
    // Compressed sync search over the top 16 bits of each subframe
    assign match = (sh_ff[79:16] == 64'h0) && (sh_ff[15:0] == `SPR_SYNC_W0) &&
                   (sf_sample[23:8] == `SPR_SYNC_W1);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sh_ff   <= '0;
            seen_ff <= 1'b0;
            scnt_ff <= '0;
        end else if (sf_stb) begin
            sh_ff <= {sh_ff[63:0], sf_sample[23:8]};
            if (match) begin
                seen_ff <= 1'b1;
                scnt_ff <= '0;
            end else if (!sf_is_b && seen_ff) begin
                if (scnt_ff == SCW'(SYNC_FRAMES - 1)) begin
                    seen_ff <= 1'b0;
                    scnt_ff <= '0;
                end else begin
                    scnt_ff <= scnt_ff + SCW'(1);
                end
            end
        end
    end

    // Non-audio and de-emphasis indications
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            non_audio_ff <= 1'b0;
            deemph_ff    <= 1'b0;
        end else begin
            non_audio_ff <= seen_ff | cs_aud_ff;
            deemph_ff    <= emph_ff & ctrl_ff[`SPR_CTRL_DEEMPH];
        end
    end

    // ==========================================================
    // Register read path
    always_comb begin
        rd_mux = 8'h00;
        if (reg_addr == `SPR_ADDR_ERR) begin
            rd_mux = {1'b0, err_ff};
        end else if (reg_addr == `SPR_ADDR_BUF_CTRL) begin
            rd_mux = ctrl_ff;
        end else if (reg_addr == `SPR_ADDR_ERR_MASK) begin
            rd_mux = err_mask_ff;
        end else if (reg_addr == `SPR_ADDR_IRQ_MASK) begin
            rd_mux = irq_mask_ff;
        end else if (reg_addr == `SPR_ADDR_CS_STAT) begin
            rd_mux[`SPR_CS_PRO]    = pro_ff;
            rd_mux[`SPR_CS_COPY]   = copy_ff;
            rd_mux[`SPR_CS_FIRST_GENERATION_FLAG]   = first_generation_flag_ff;
            rd_mux[`SPR_CS_AUDIO]  = non_audio_ff;
            rd_mux[`SPR_CS_EMPH]   = emph_ff;
            rd_mux[`SPR_CS_DEEMPH] = deemph_ff;
        end else if (reg_addr == `SPR_ADDR_LINK) begin
            rd_mux[`SPR_LINK_LOCK]            = lock_ff;
            rd_mux[`SPR_LINK_SYNC]            = seen_ff;
            rd_mux[`SPR_LINK_V]               = v_live_ff;
            rd_mux[`SPR_LINK_WLEN_LO +: 4]    = wlen_ff;
        end
    end

    // Buffer window index and kind chosen by software beforehand
    assign buf_idx     = 5'(reg_addr - `SPR_ADDR_BUF_BASE);
    assign mif.rd_en   = reg_rd && in_buf(reg_addr);
    assign mif.rd_addr = {1'b0, buf_idx} + (ctrl_ff[`SPR_CTRL_BUFFER_KIND_SELECT] ? 6'(BUF_WORDS) : 6'h00);

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            rd_q_ff      <= '0;
            buf_rd_ff    <= 1'b0;
            fmt_user_ff  <= 1'b0;
            fmt_two_ff   <= 1'b0;
            fmt_pickb_ff <= 1'b0;
        end else begin
            rd_q_ff   <= (reg_rd && !in_buf(reg_addr)) ? rd_mux : 8'h00;
            buf_rd_ff <= reg_rd && in_buf(reg_addr);
            if (reg_rd) begin
                fmt_user_ff  <= ctrl_ff[`SPR_CTRL_BUFFER_KIND_SELECT];
                fmt_two_ff   <= ctrl_ff[`SPR_CTRL_CAM];
                fmt_pickb_ff <= ctrl_ff[`SPR_CTRL_PICKB];
            end
        end
    end

    // Two-byte words for user data or width select; else one picked byte
    always_comb begin
        reg_rdata = {8'h00, rd_q_ff};
        if (buf_rd_ff) begin
            if (fmt_user_ff || fmt_two_ff) begin
                reg_rdata = mif.rd_data;
            end else begin
                reg_rdata = {8'h00, fmt_pickb_ff ? mif.rd_data[7:0]
                                                 : mif.rd_data[15:8]};
            end
        end
    end

    assign audio_out      = audio_out_ff;
    assign audio_stb      = audio_stb_ff;
    assign audio_is_b     = audio_is_b_ff;
    assign deemph_on      = deemph_ff;
    assign non_audio      = non_audio_ff;
    assign rx_fault_irq   = rx_fault_irq_ff;
    assign buf_change_irq = buf_change_irq_ff;

    // ==========================================================
    // Checks
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    lock_read_a: assert property (reg_rd && reg_addr == `SPR_ADDR_LINK |=>
        reg_rdata[`SPR_LINK_LOCK] == $past(pll_locked, 2)) else $error("lock flag wrong");
    err_sticky_a: assert property (!clr_err |=>
        (err_ff & $past(err_ff)) == $past(err_ff)) else $error("error flag lost");
    err_setwins_a: assert property (clr_err && |logged |=>
        err_ff == $past(logged)) else $error("event lost on clear");
    mask_gate_a: assert property (1'b1 |=>
        (err_ff & ~$past(err_ff) & ~$past(err_mask_ff[6:0])) == 7'h00) else $error("masked logged");
    fault_irq_a: assert property (|logged |=> rx_fault_irq) else $error("no fault irq");
    hold_zero_a: assert property (sf_stb && hit && hold == SPR_HOLD_ZERO |=>
        audio_stb && audio_out == 24'h000000) else $error("mute failed");
    sample_pass_a: assert property (sf_stb && !hit |=>
        audio_out == $past(sf_sample)) else $error("sample altered");
    sync_seen_a: assert property (sf_stb && match |=> ##1 non_audio)
        else $error("sync not flagged");
    copy_len_a: assert property (blk_done && st_ff == SPR_IDLE |=>
        (st_ff == SPR_COPY)[*8]) else $error("copy ended early");
    chg_irq_a: assert property (st_ff == SPR_COPY && !copy_chg_ff |=>
        !buf_change_irq) else $error("irq without change");
endmodule

// [spr_params.svh]
// Offsets, field positions, reset values and counts of the receiver status block
`ifndef SPR_PARAMS_SVH
`define SPR_PARAMS_SVH

// ==========================================================
// Register offsets
`define SPR_ADDR_IRQ_MASK  8'h21
`define SPR_ADDR_BUF_CTRL  8'h24
`define SPR_ADDR_ERR       8'h25
`define SPR_ADDR_CS_STAT   8'h26
`define SPR_ADDR_ERR_MASK  8'h27
`define SPR_ADDR_LINK      8'h28
`define SPR_ADDR_BUF_BASE  8'h4a
`define SPR_ADDR_BUF_END   8'h62

// ==========================================================
// Buffer control fields
`define SPR_CTRL_SSEL      0
`define SPR_CTRL_BUFFER_KIND_SELECT      1
`define SPR_CTRL_CAM       2
`define SPR_CTRL_PICKB     3
`define SPR_CTRL_HOLD_LO   4
`define SPR_CTRL_DEEMPH    6

// ==========================================================
// Error register fields
`define SPR_ERR_PAR        0
`define SPR_ERR_BIP        1
`define SPR_ERR_EYE_MARGIN_WARNING       2
`define SPR_ERR_V          3
`define SPR_ERR_UNLOCK     4
`define SPR_ERR_SUBCODE_CHECK_ERROR       5
`define SPR_ERR_STATUS_BLOCK_CHECK_ERROR       6
`define SPR_ERR_AUDIO      7'h1f

// ==========================================================
// Status fields
`define SPR_IRQ_BUFCHG     0
`define SPR_CS_PRO         0
`define SPR_CS_COPY        1
`define SPR_CS_FIRST_GENERATION_FLAG        2
`define SPR_CS_AUDIO       3
`define SPR_CS_EMPH        4
`define SPR_CS_DEEMPH      5
`define SPR_LINK_LOCK      0
`define SPR_LINK_SYNC      1
`define SPR_LINK_V         2
`define SPR_LINK_WLEN_LO   4

// ==========================================================
// Reset values, counts and sync words
`define SPR_CTRL_RST       8'h00
`define SPR_MASK_RST       8'h00
`define SPR_BUF_WORDS      24
`define SPR_BLOCK_FRAMES   192
`define SPR_SYNC_TIMEOUT   4096
`define SPR_SYNC_W0        16'hf872
`define SPR_SYNC_W1        16'h4e1f

`endif

// [spr_pkg.sv]
// Types shared by the receiver status block
package spr_pkg;
    typedef enum logic [1:0] {
        SPR_HOLD_PREV = 2'h0,
        SPR_HOLD_ZERO = 2'h1,
        SPR_HOLD_NONE = 2'h2
    } spr_hold_t;
    typedef enum logic [1:0] {
        SPR_IDLE = 2'h1,
        SPR_COPY = 2'h2
    } spr_copy_st_t;
    typedef logic [15:0] spr_word_t;
endpackage

// [spr_mem_if.sv]
// Connection between the status block and its host buffer memory
`timescale 1ns/100ps
interface spr_mem_if #(
    parameter int AW = 6,
    parameter int DW = 16
);
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic          rd_en;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;
    modport owner (output wr_en, wr_addr, wr_data, rd_en, rd_addr, input rd_data);
    modport store (input wr_en, wr_addr, wr_data, rd_en, rd_addr, output rd_data);
endinterface

// [spr_blk_mem.sv]
// Host-side block buffer with registered read data
`timescale 1ns/100ps
module spr_blk_mem #(
    parameter int AW    = 6,
    parameter int DW    = 16,
    parameter int DEPTH = 48
)(
    input wire logic mclk,
    spr_mem_if.store m
);
    logic [DW-1:0] mem [DEPTH];
    logic [DW-1:0] rd_q_ff;

    // ==========================================================
    // Write port, filled by the block copy
    always_ff @(posedge mclk) begin
        if (m.wr_en) begin
            mem[m.wr_addr] <= m.wr_data;
        end
    end

    // ==========================================================
    // Read port, data one cycle after the request
    always_ff @(posedge mclk) begin
        if (m.rd_en) begin
            rd_q_ff <= mem[m.rd_addr];
        end
    end

    assign m.rd_data = rd_q_ff;
endmodule

// [spr_tx_model.sv]
// Far-side transmitter model that hands decoded subframes to the block
`timescale 1ns/100ps
module spr_tx_model (
    input  wire logic        mclk,
    output logic      [29:0] fr
);
    initial fr = 30'h0;
    // One strobed subframe; afterwards the lines show the inverse so stale data never looks valid
    task automatic send(input logic [28:0] f);
        @(posedge mclk);
        fr <= {1'b1, f};
        @(posedge mclk);
        fr <= {1'b0, ~f};
    endtask
endmodule

// [tb_spdif_rx_status_buffers.sv]
// Self-checking bench for the receiver status block
`timescale 1ns/100ps
module tb_spdif_rx_status_buffers;
    logic        mclk, rstn, reg_wr, reg_rd, pll_locked, cbe, lce, eye, qce, sce;
    logic [7:0]  reg_addr, reg_wdata;
    logic [15:0] reg_rdata, d;
    logic [23:0] audio_out, o;
    logic [29:0] fr;
    logic        audio_stb, audio_is_b, deemph_on, non_audio, rx_fault_irq, buf_change_irq;
    int          n_errors = 0, compares = 0, n_irq = 0, n_bc = 0, cyc = 0, n;
    spr_tx_model tx_u (.mclk(mclk), .fr(fr));
    spr_rx_status #(.SYNC_FRAMES(8)) dut_u (
        .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_locked(pll_locked), .sf_stb(fr[29]),
        .sf_is_b(fr[28]), .sf_block_start(fr[27]), .sf_c(fr[26]), .sf_u(fr[25]), .sf_v(fr[24]),
        .sf_sample(fr[23:0]), .check_bit_error(cbe), .line_code_error(lce),
        .eye_margin_warning(eye), .subcode_check_error(qce), .status_block_check_error(sce),
        .audio_out(audio_out), .audio_stb(audio_stb), .audio_is_b(audio_is_b),
        .deemph_on(deemph_on), .non_audio(non_audio), .rx_fault_irq(rx_fault_irq),
        .buf_change_irq(buf_change_irq));
    // ==========================================================
    // Clock, pulse counters and hang limit
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        n_irq += int'(rx_fault_irq);
        n_bc += int'(buf_change_irq);
        if (cyc == 12000) begin
            n_errors++;
            print_verdict();
        end
    end
    // ==========================================================
    // Shared bus and stream tasks
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    // Read; an event pulse may ride on the strobe edge
    task automatic rd(input logic [7:0] a, input logic ev);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        qce <= ev;
        @(posedge mclk);
        reg_rd <= 1'b0;
        qce <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic sub(input logic b, input logic [23:0] s, input logic e, input logic q);
        lce <= e;
        qce <= q;
        tx_u.send({b, 4'h0, s});
        lce <= 1'b0;
        qce <= 1'b0;
        #1;
        o = audio_out;
        chk(24'({audio_stb, audio_is_b}), 24'({1'b1, b}));
    endtask
    // Block: A status bit 0 from the argument, bits 2, 3 and 7 set, user bit A frame 0 and B frame 1
    task automatic blk(input logic broadcast_class_bit);
        for (int f = 0; f < 192; f++) begin
            tx_u.send({1'b0, f == 0, (f == 0) ? broadcast_class_bit : (f == 2 || f == 3 || f == 7),
                       f == 0, 1'b0, 24'(f)});
            tx_u.send({1'b1, 1'b0, 1'b0, f == 1, 1'b0, 24'(f)});
        end
        repeat (60) @(posedge mclk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_masked();
        rd(8'h28, 1'b0);
        chk(24'(d[0]), 24'h1);
        pll_locked <= 1'b0;
        rd(8'h28, 1'b0);
        chk(24'(d[0]), 24'h0);
        pll_locked <= 1'b1;
        wr(8'h24, 8'h10);
        sub(1'b0, 24'h123456, 1'b1, 1'b0);
        chk(o, 24'h123456);
        rd(8'h25, 1'b0);
        chk(d, 24'h0);
        chk(24'(n_irq), 24'h0);
    endtask
    task automatic t_unmasked();
        wr(8'h27, 8'h7f);
        sub(1'b0, 24'habcdef, 1'b1, 1'b0);
        chk(o, 24'h0);
        chk(24'(rx_fault_irq), 24'h1);
        rd(8'h25, 1'b0);
        chk(d, 24'h0002);
        rd(8'h25, 1'b0);
        chk(d, 24'h0);
        wr(8'h24, 8'h00);
        sub(1'b0, 24'h111111, 1'b0, 1'b0);
        chk(o, 24'h111111);
        sub(1'b0, 24'h222222, 1'b1, 1'b0);
        chk(o, 24'h111111);
        sub(1'b0, 24'h333333, 1'b0, 1'b1);
        chk(o, 24'h333333);
        rd(8'h25, 1'b1);
        chk(d, 24'h0022);
        rd(8'h25, 1'b0);
        chk(d, 24'h0020);
    endtask
    task automatic t_blocks();
        wr(8'h21, 8'h01);
        blk(1'b1);
        wr(8'h24, 8'h04);
        rd(8'h4a, 1'b0);
        chk(d, 24'hb100);
        wr(8'h24, 8'h00);
        rd(8'h4a, 1'b0);
        chk(24'(d[15:8] | d[7:0]), 24'hb1);
        wr(8'h24, 8'h08);
        rd(8'h4a, 1'b0);
        chk(24'(d[15:8] | d[7:0]), 24'h0);
        wr(8'h24, 8'h06);
        rd(8'h4a, 1'b0);
        chk(d, 24'h9000);
        rd(8'h26, 1'b0);
        chk(24'(d[0]), 24'h1);
        n = n_bc;
        wr(8'h24, 8'h07);
        blk(1'b1);
        chk(24'(n_bc - n), 24'h0);
        rd(8'h26, 1'b0);
        chk(24'(d[0]), 24'h0);
        wr(8'h24, 8'h46);
        blk(1'b0);
        chk(24'(n_bc - n), 24'h1);
        rd(8'h26, 1'b0);
        chk(24'(d[1:0]), 24'h2);
        chk(24'(d[5:4]), 24'h3);
        chk(24'(deemph_on), 24'h1);
    endtask
    task automatic t_sync();
        logic [15:0] w [6] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'hf872, 16'h4e1f};
        for (int i = 0; i < 6; i++) sub(i[0], {w[i], 8'h00}, 1'b0, 1'b0);
        repeat (2) @(posedge mclk);
        #1;
        chk(24'(non_audio), 24'h1);
        for (int i = 0; i < 14; i++) sub(i[0], 24'h0, 1'b0, 1'b0);
        chk(24'(non_audio), 24'h1);
        for (int i = 0; i < 6; i++) sub(i[0], 24'h0, 1'b0, 1'b0);
        chk(24'(non_audio), 24'h0);
    endtask
    // ==========================================================
    // Verdict and main sequence
    task automatic print_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        pll_locked = 1'b1;
        {reg_wr, reg_rd, cbe, lce, eye, qce, sce} = 7'h00;
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        t_masked();
        t_unmasked();
        t_blocks();
        t_sync();
        print_verdict();
    end
endmodule
